// ### src/reset_source_controller.sv
`timescale 1ns/100ps
// How it works
// (R1) enable bit turns supply monitor on/off
// (R2) supply reset needs source selection too
// (R3) software waits before selecting supply monitor
// (R4) status bit shows live supply level
// (R5) low six control bits unused
// (R6) low pin level holds device in reset
// (R7) pin reset sets flag bit zero
// (R8) clock-loss timeout forces a reset
// (R9) clock-loss flag marks only its reset
// (R10) clock-loss bit write enables detector
// (R11) internal resets never drive the pin
// (R12) comparator bit write enables comparator reset
// (R13) software lets comparator settle before enabling
// (R14) low comparator output resets when enabled
// (R15) comparator flag marks only its reset
// (R16) watchdog overflow resets, sets flag three
// (R17) flash write above limit resets
// (R18) code read above limit resets
// (R19) fetch above limit resets
// (R20) security-blocked flash access resets
// (R21) flash error reset sets flag six
// (R22) software bit write forces reset
// (R23) power-on or supply reset sets flag one
// (R24) other resets clear power-on flag
// (R25) software writes whole reset cause values
// (R26) reset held one cycle past request
// (R27) flags survive, change only on reset
module reset_source_controller (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rst_pin_i,
   output logic rst_pin_o,
   output logic rst_pin_oe,
   input wire logic supply_above,
   output logic supply_monitor_enable,
   input wire logic comparator_out,
   input wire logic clock_loss_timeout,
   output logic missing_clock_detector_enable,
   input wire logic watchdog_overflow,
   input wire logic flash_write_enable,
   input wire rst_pkg::flash_access_type data_space_move,
   input wire rst_pkg::flash_access_type code_space_read,
   input wire rst_pkg::flash_access_type fetch,
   input wire logic flash_security_block,
   output logic sys_reset_n
);
   import rst_pkg::*;

   state_type st_q;
   state_type st_d;
   logic [cause_count-1:0] req;
   logic flash_err;
   logic setup;
   logic hit_vdm;
   logic hit_cause;
   logic wr_vdm;
   logic wr_cause;

   function automatic logic [cause_count-1:0] pick_cause(input logic [cause_count-1:0] c);
      logic [cause_count-1:0] r;
      r = '0;
      // supply loss wins: it owns the pin and the power-on flag
      if (c[power_on_flag_bit]) begin
         r[power_on_flag_bit] = 1'b1;
      end else begin
         for (int i = cause_count - 1; i >= 0; i--) begin
            if (c[i]) begin
               r = '0;
               r[i] = 1'b1;
            end
         end
      end
      return r;
   endfunction

   assign setup = psel && !penable;
   assign hit_vdm = paddr == supply_monitor_control_addr;
   assign hit_cause = paddr == reset_cause_addr;
   assign wr_vdm = psel && penable && pwrite && hit_vdm;
   assign wr_cause = psel && penable && pwrite && hit_cause;

   // flash checks; the flash controller flags security blocks itself
   assign flash_err = (flash_write_enable && data_space_move.valid &&
                       data_space_move.addr > user_code_limit) || // R17
                      (code_space_read.valid && code_space_read.addr > user_code_limit) || // R18
                      (fetch.valid && fetch.addr > user_code_limit) || // R19
                      flash_security_block; // R20

   always_comb begin
      req = '0;
      req[pin_reset_flag_bit] = !st_q.sync2[sync_pin] && st_q.pin_mask == 2'h0; // R6
      req[power_on_flag_bit] = st_q.vdm_en && st_q.vdm_sel && !st_q.sync2[sync_supply]; // R2
      req[clock_loss_bit] = st_q.mcd_en && st_q.sync2[sync_mcd]; // R8
      req[watchdog_reset_flag_bit] = watchdog_overflow; // R16
      req[software_reset_bit] = st_q.sw_req; // R22
      req[comparator_reset_bit] = st_q.cmp_en && !st_q.sync2[sync_cmp]; // R14
      req[flash_error_flag_bit] = flash_err; // R21
   end

   always_comb begin
      st_d = st_q;
      st_d.sync1 = {clock_loss_timeout, comparator_out, supply_above, rst_pin_i};
      st_d.sync2 = st_q.sync1;
      if (rst_pin_oe) begin
         st_d.pin_mask = pin_mask_cycles;
      end else if (st_q.pin_mask != 2'h0) begin
         st_d.pin_mask = st_q.pin_mask - 2'h1;
      end
      if (setup) begin
         st_d.rdata = '0;
         if (hit_vdm) begin
            st_d.rdata[supply_monitor_enable_bit] = st_q.vdm_en;
            st_d.rdata[supply_level_status_bit] = st_q.sync2[sync_supply]; // R4
         end else if (hit_cause) begin
            st_d.rdata[cause_count-1:0] = st_q.flags;
         end
      end
      if (wr_vdm) begin
         st_d.vdm_en = pwdata[supply_monitor_enable_bit]; // R1
      end
      if (wr_cause) begin
         // write values land in the enables; reads keep showing the flags
         st_d.vdm_sel = pwdata[power_on_flag_bit]; // R2
         st_d.mcd_en = pwdata[clock_loss_bit]; // R10
         st_d.cmp_en = pwdata[comparator_reset_bit]; // R12
         st_d.sw_req = pwdata[software_reset_bit]; // R22
      end
      case (st_q.seq)
         seq_idle: begin
            if (|req) begin
               st_d.seq = seq_active;
               st_d.cause = pick_cause(req);
               st_d.mcd_en = 1'b0;
               st_d.cmp_en = 1'b0;
               st_d.sw_req = 1'b0;
            end
         end
         seq_active: begin
            st_d.cause = pick_cause(st_q.cause | req);
            st_d.sw_req = 1'b0;
            if (!(|req)) begin
               st_d.seq = seq_hold; // R26
            end
         end
         seq_hold: begin
            if (|req) begin
               st_d.seq = seq_active;
               st_d.cause = pick_cause(st_q.cause | req);
            end else begin
               st_d.seq = seq_idle;
               // one-hot cause: power-on clears the rest, any other clears power-on
               st_d.flags = st_q.cause; // R7 R9 R15 R21 R23 R24 R27
               if (st_q.cause[power_on_flag_bit]) begin
                  st_d.vdm_en = 1'b1;
               end
            end
         end
         default: begin
            st_d.seq = seq_active;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= '{sync1: sync_rst, sync2: sync_rst, seq: seq_hold, cause: por_cause,
                   flags: '0, vdm_en: supply_monitor_enable_rst, vdm_sel: supply_select_rst,
                   mcd_en: 1'b0, cmp_en: 1'b0, sw_req: 1'b0, pin_mask: pin_mask_cycles,
                   rdata: '0};
      end else begin
         st_q <= st_d;
      end
   end

   assign prdata = st_q.rdata;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !(hit_vdm || hit_cause);
   assign sys_reset_n = st_q.seq == seq_idle;
   // only supply loss or power-on pulls the pin low
   assign rst_pin_oe = st_q.seq != seq_idle && st_q.cause[power_on_flag_bit]; // R11
   assign rst_pin_o = 1'b0;
   assign supply_monitor_enable = st_q.vdm_en; // R1
   assign missing_clock_detector_enable = st_q.mcd_en; // R10

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence apb_write_cause;
      psel && penable && pwrite && hit_cause;
   endsequence

   sequence apb_read_vdm;
      psel && !penable && !pwrite && hit_vdm ##1 psel && penable;
   endsequence

   sequence request_ends;
      st_q.seq == seq_active ##0 !(|req);
   endsequence

   sequence reset_exit;
      st_q.seq == seq_hold && !(|req);
   endsequence

   sequence idle_entry;
      st_q.seq == seq_idle && (|req);
   endsequence

   sequence apb_read_cause;
      psel && !penable && !pwrite && hit_cause ##1 psel && penable;
   endsequence

   a_vdm_enable_write: assert property ( // R1
      wr_vdm |=> supply_monitor_enable == $past(pwdata[supply_monitor_enable_bit]))
      else $error("supply monitor enable did not follow write");

   a_supply_gated: assert property ( // R2
      (sys_reset_n && !st_q.vdm_sel && !(|(req & 7'h7d))) |=> sys_reset_n)
      else $error("supply monitor reset while not selected");

   a_status_live: assert property ( // R4
      apb_read_vdm |-> prdata[supply_level_status_bit] == $past(st_q.sync2[sync_supply]))
      else $error("supply status not live");

   a_unused_zero: assert property ( // R5
      apb_read_vdm |-> prdata[5:0] == 6'h00)
      else $error("unused control bits not zero");

   a_pin_enters: assert property ( // R6
      (!st_q.sync2[sync_pin] && st_q.pin_mask == 2'h0) |=> !sys_reset_n)
      else $error("pin request did not reset");

   a_pin_flag: assert property ( // R7
      (st_q.seq == seq_hold && st_q.cause == 7'h01 && !(|req)) |=> st_q.flags == 7'h01)
      else $error("pin flag not set on exit");

   a_clock_loss: assert property ( // R8
      (st_q.mcd_en && st_q.sync2[sync_mcd]) |=> !sys_reset_n)
      else $error("clock loss did not reset");

   a_pin_quiet: assert property ( // R11
      rst_pin_oe |-> st_q.cause == por_cause)
      else $error("internal reset drove the pin");

   a_cmp_reset: assert property ( // R14
      (st_q.cmp_en && !st_q.sync2[sync_cmp]) |=> !sys_reset_n)
      else $error("comparator low did not reset");

   a_wdt_reset: assert property ( // R16
      watchdog_overflow |=> !sys_reset_n ##[1:8] st_q.flags[watchdog_reset_flag_bit] || !sys_reset_n)
      else $error("watchdog overflow did not reset");

   a_flash_limit: assert property ( // R17
      (flash_write_enable && data_space_move.valid && data_space_move.addr > user_code_limit)
      |=> !sys_reset_n)
      else $error("flash write above limit did not reset");

   a_sw_force: assert property ( // R22
      apb_write_cause ##0 pwdata[software_reset_bit] |-> ##2 !sys_reset_n)
      else $error("software reset not forced");

   a_hold_extra: assert property ( // R26
      request_ends |=> !sys_reset_n)
      else $error("reset released without extra cycle");

   a_flags_stable: assert property ( // R27
      st_q.seq != seq_hold |=> $stable(st_q.flags))
      else $error("flags changed outside reset exit");

   a_por_exclusive: assert property ( // R24
      st_q.flags[power_on_flag_bit] |-> st_q.flags == por_cause)
      else $error("power-on flag shared with another");

   a_cmp_enable_write: assert property ( // R12
      (wr_cause && !(st_q.seq == seq_idle && (|req))) |=> st_q.cmp_en == $past(pwdata[comparator_reset_bit]))
      else $error("comparator enable did not follow write");

   a_mcd_enable_write: assert property ( // R10
      (wr_cause && !(st_q.seq == seq_idle && (|req))) |=> missing_clock_detector_enable == $past(pwdata[clock_loss_bit]))
      else $error("clock-loss enable did not follow write");

   a_clock_loss_flag: assert property ( // R9
      reset_exit ##0 st_q.cause[clock_loss_bit] |=> st_q.flags == 7'h04)
      else $error("clock-loss flag wrong on exit");

   a_cmp_flag: assert property ( // R15
      reset_exit ##0 st_q.cause[comparator_reset_bit] |=> st_q.flags == 7'h20)
      else $error("comparator flag wrong on exit");

   a_wdt_flag: assert property ( // R16
      reset_exit ##0 st_q.cause[watchdog_reset_flag_bit] |=> st_q.flags == 7'h08)
      else $error("watchdog flag wrong on exit");

   a_flash_flag: assert property ( // R21
      reset_exit ##0 st_q.cause[flash_error_flag_bit] |=> st_q.flags == 7'h40)
      else $error("flash error flag wrong on exit");

   a_sw_flag: assert property ( // R22
      reset_exit ##0 st_q.cause[software_reset_bit] |=> st_q.flags == 7'h10)
      else $error("software flag wrong on exit");

   a_por_flag: assert property ( // R23
      reset_exit ##0 st_q.cause[power_on_flag_bit] |=> st_q.flags == 7'h02)
      else $error("power-on flag wrong on exit");

   a_flags_onehot: assert property ( // R9
      $onehot0(st_q.flags))
      else $error("more than one cause flag set");

   a_code_read_limit: assert property ( // R18
      (code_space_read.valid && code_space_read.addr > user_code_limit) |=> !sys_reset_n)
      else $error("code read above limit did not reset");

   a_fetch_limit: assert property ( // R19
      (fetch.valid && fetch.addr > user_code_limit) |=> !sys_reset_n)
      else $error("fetch above limit did not reset");

   a_security_block: assert property ( // R20
      flash_security_block |=> !sys_reset_n)
      else $error("blocked flash access did not reset");

   a_upper_zero: assert property ( // R5
      apb_read_vdm |-> prdata[31:8] == 24'h000000)
      else $error("upper control bits not zero");

   a_oe_por_only: assert property ( // R11
      !st_q.cause[power_on_flag_bit] |-> !rst_pin_oe)
      else $error("pin driven for internal cause");

   a_supply_reset: assert property ( // R2
      (st_q.vdm_en && st_q.vdm_sel && !st_q.sync2[sync_supply]) |=> !sys_reset_n)
      else $error("selected supply loss did not reset");

   a_supply_off_quiet: assert property ( // R1
      !st_q.vdm_en |-> !req[power_on_flag_bit])
      else $error("disabled supply monitor requested reset");

   a_reset_stays: assert property ( // R26
      (st_q.seq == seq_active && (|req)) |=> !sys_reset_n)
      else $error("reset released while request stands");

   a_ready_always: assert property (
      (psel && penable) |-> pready)
      else $error("access phase not answered");

   a_slverr_mapped: assert property (
      (psel && penable && (hit_vdm || hit_cause)) |-> !pslverr)
      else $error("error on mapped register");

   a_cmp_off_quiet: assert property ( // R14
      !st_q.cmp_en |-> !req[comparator_reset_bit])
      else $error("disabled comparator requested reset");

   a_mcd_off_quiet: assert property ( // R10
      !st_q.mcd_en |-> !req[clock_loss_bit])
      else $error("disabled clock-loss detector requested reset");

   a_rdata_cause: assert property ( // R27
      apb_read_cause |-> prdata[cause_count-1:0] == $past(st_q.flags))
      else $error("cause read did not show flags");

   a_enables_cleared: assert property (
      idle_entry |=> !st_q.mcd_en && !st_q.cmp_en)
      else $error("enables survived reset entry");
endmodule

// ### src/rst_pkg.sv
package rst_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] supply_monitor_control_idx = 8'hff;
   localparam logic [7:0] reset_cause_idx = 8'hef;
   localparam logic [11:0] supply_monitor_control_addr = {2'h0, supply_monitor_control_idx, 2'h0};
   localparam logic [11:0] reset_cause_addr = {2'h0, reset_cause_idx, 2'h0};
   // supply monitor control fields
   localparam int supply_monitor_enable_bit = 7;
   localparam int supply_level_status_bit = 6;
   // reset cause fields; each cause uses the bit of its flag
   localparam int pin_reset_flag_bit = 0;
   localparam int power_on_flag_bit = 1;
   localparam int clock_loss_bit = 2;
   localparam int watchdog_reset_flag_bit = 3;
   localparam int software_reset_bit = 4;
   localparam int comparator_reset_bit = 5;
   localparam int flash_error_flag_bit = 6;
   localparam int cause_count = 7;
   // reset values
   localparam logic [6:0] por_cause = 7'h02;
   localparam logic supply_monitor_enable_rst = 1'b1;
   localparam logic supply_select_rst = 1'b1;
   // synchroniser lanes: pin, supply level, comparator, clock-loss one-shot
   localparam int sync_count = 4;
   localparam int sync_pin = 0;
   localparam int sync_supply = 1;
   localparam int sync_cmp = 2;
   localparam int sync_mcd = 3;
   localparam logic [3:0] sync_rst = 4'h7;
   // own pin drive echoes back through the synchroniser
   localparam logic [1:0] pin_mask_cycles = 2'h3;
   localparam logic [15:0] user_code_limit = 16'h3dff;

   typedef enum logic [1:0] {seq_idle, seq_active, seq_hold} seq_type;

   typedef struct packed {
      logic valid;
      logic [15:0] addr;
   } flash_access_type;

   typedef struct packed {
      logic [sync_count-1:0] sync1;
      logic [sync_count-1:0] sync2;
      seq_type seq;
      logic [cause_count-1:0] cause;
      logic [cause_count-1:0] flags;
      logic vdm_en;
      logic vdm_sel;
      logic mcd_en;
      logic cmp_en;
      logic sw_req;
      logic [1:0] pin_mask;
      logic [31:0] rdata;
   } state_type;
endpackage

// ### verif/ext_reset_model.sv
`timescale 1ns/100ps
// external reset circuit on the pin; the pin has a pull-up
module ext_reset_model #(
   parameter int hold_cycles = 4
) (
   input wire logic pclk,
   input wire logic req,
   input wire logic rst_pin_o,
   input wire logic rst_pin_oe,
   output logic rst_pin_i
);
   logic [3:0] left_q = 4'h0;
   always @(posedge pclk) begin
      if (req) begin
         left_q <= 4'(hold_cycles);
      end else if (left_q != 4'h0) begin
         left_q <= left_q - 4'h1;
      end
   end
   // either party pulls low; otherwise the pull-up wins
   assign rst_pin_i = ((left_q != 4'h0) || (rst_pin_oe && (rst_pin_o == 1'b0))) ? 1'b0 : 1'b1;
endmodule

// ### verif/reset_source_controller_tb.sv
`timescale 1ns/100ps
module reset_source_controller_tb;
   import rst_pkg::*;
   typedef struct packed {logic [3:0] kind; logic [6:0] flags;} row_type;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, perr, rst_pin_i, rst_pin_o, rst_pin_oe, sme, mcde, sys_reset_n;
   logic pin_req = 0, supply_above = 1, comparator_out = 1, clock_loss_timeout = 0, watchdog_overflow = 0;
   logic flash_write_enable = 0, flash_security_block = 0, saw_rst = 0, saw_oe = 0;
   flash_access_type data_space_move = '0, code_space_read = '0, fetch = '0;
   int num_errors = 0, n_compared = 0, cyc = 0;
   row_type rows[10] = '{'{4'h0, 7'h01}, '{4'h1, 7'h08}, '{4'h2, 7'h10}, '{4'h3, 7'h40}, '{4'h4, 7'h40},
      '{4'h5, 7'h40}, '{4'h6, 7'h40}, '{4'h7, 7'h20}, '{4'h8, 7'h04}, '{4'h9, 7'h02}};
   always #2 pclk = ~pclk;
   ext_reset_model pin (.pclk(pclk), .req(pin_req), .rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe),
      .rst_pin_i(rst_pin_i));
   reset_source_controller dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rst_pin_i(rst_pin_i), .rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe), .supply_above(supply_above),
      .supply_monitor_enable(sme), .comparator_out(comparator_out), .clock_loss_timeout(clock_loss_timeout),
      .missing_clock_detector_enable(mcde), .watchdog_overflow(watchdog_overflow),
      .flash_write_enable(flash_write_enable), .data_space_move(data_space_move),
      .code_space_read(code_space_read), .fetch(fetch), .flash_security_block(flash_security_block),
      .sys_reset_n(sys_reset_n));
   // sticky watchers so short reset pulses are not missed between polls
   always @(posedge pclk) begin
      if (sys_reset_n === 1'b0) saw_rst <= 1'b1;
      if (rst_pin_oe === 1'b1) saw_oe <= 1'b1;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         num_errors++;
         print_verdict();
      end
   end
   task automatic print_verdict;
      $display("compared %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic idle;
      pin_req <= 0;
      watchdog_overflow <= 0;
      flash_write_enable <= 0;
      data_space_move <= '0;
      code_space_read <= '0;
      fetch <= '0;
      flash_security_block <= 0;
      comparator_out <= 1;
      clock_loss_timeout <= 0;
      supply_above <= 1;
   endtask
   task automatic wait_reset;
      int n;
      n = 0;
      while (sys_reset_n !== 1'b0 && n < 40) begin
         @(posedge pclk);
         n++;
      end
      while (sys_reset_n !== 1'b1 && n < 80) begin
         @(posedge pclk);
         n++;
      end
      check({31'h0, n < 80}, 32'h1);
      repeat (4) @(posedge pclk); // pin echo mask runs out
   endtask
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      repeat (6) @(posedge pclk);
      foreach (rows[i]) begin
         @(posedge pclk);
         saw_oe = 0;
         case (rows[i].kind)
            4'h0: pin_req <= 1;
            4'h1: watchdog_overflow <= 1;
            4'h2: apb(1, reset_cause_addr, 32'h12);
            4'h3: begin
               flash_write_enable <= 1;
               data_space_move <= '{1'b1, 16'h3e00};
            end
            4'h4: code_space_read <= '{1'b1, 16'h3e00};
            4'h5: fetch <= '{1'b1, 16'hffff};
            4'h6: flash_security_block <= 1;
            4'h7: begin
               apb(1, reset_cause_addr, 32'h22);
               comparator_out <= 0;
            end
            4'h8: begin
               apb(1, reset_cause_addr, 32'h06);
               @(posedge pclk);
               check({31'h0, mcde}, 32'h1);
               clock_loss_timeout <= 1;
            end
            default: supply_above <= 0;
         endcase
         @(posedge pclk);
         idle();
         wait_reset();
         check({31'h0, saw_oe}, {31'h0, rows[i].kind == 4'h9});
         apb(0, reset_cause_addr, 32'h0);
         check(rd, {25'h0, rows[i].flags});
      end
      // second power-on reset in mid-run
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      check({31'h0, rst_pin_oe}, 32'h1);
      presetn <= 1'b1;
      repeat (6) @(posedge pclk);
      apb(0, reset_cause_addr, 32'h0);
      check(rd, 32'h02);
      apb(0, supply_monitor_control_addr, 32'h0);
      check(rd, 32'hc0);
      // enable off, low bits written: no effect on them
      apb(1, supply_monitor_control_addr, 32'h3f);
      @(posedge pclk);
      check({31'h0, sme}, 32'h0);
      // deselect supply, drop the level: live status, no reset, flags kept
      apb(1, reset_cause_addr, 32'h0);
      apb(1, supply_monitor_control_addr, 32'h80);
      saw_rst = 0;
      supply_above <= 0;
      repeat (4) @(posedge pclk);
      apb(0, supply_monitor_control_addr, 32'h0);
      check(rd, 32'h80);
      supply_above <= 1;
      // limit address itself, and write enable off, stay legal
      flash_write_enable <= 1;
      data_space_move <= '{1'b1, 16'h3dff};
      @(posedge pclk);
      flash_write_enable <= 0;
      data_space_move <= '{1'b1, 16'h3e00};
      @(posedge pclk);
      idle();
      repeat (6) @(posedge pclk);
      check({31'h0, saw_rst}, 32'h0);
      apb(0, reset_cause_addr, 32'h0);
      check(rd, 32'h02);
      apb(0, 12'h000, 32'h0);
      check({rd[31:1], perr}, 32'h1);
      print_verdict();
   end
endmodule
